// >>> rtl/codec_ctl_consts.svh
// Constants for the codec level and clock control block
`ifndef CODEC_CTL_CONSTS_SVH
`define CODEC_CTL_CONSTS_SVH
`define SAMPLE_W 24
`define GAIN_W 6
`define VOL_W 8
`define TIME_W 8
`define COUNT_W 4
`define ADC_RATE_DIV 256
`define MOD_LIMIT_HALF 2'h1
`define MOD_LIMIT_QUARTER 2'h3
`define DAC_LIMIT_8X 8'hff
`define DAC_LIMIT_4X 8'h7f
`define MUTE_RESET 2'h3
`define VOL_MANT_SHIFT 8
`define VOL_FRAC_BITS 4
`endif

// >>> rtl/codec_pkg.sv
// Types for the codec level and clock control block
`include "codec_ctl_consts.svh"
package codec_pkg;
	typedef enum logic [1:0] {alc_idle, alc_attack, alc_recover} alc_state_type;
	typedef enum logic [1:0] {recovery_none, recovery_normal, recovery_limited} recovery_mode_type;
	typedef enum logic [2:0] {
		source_playback, source_auxiliary, source_rate_converter, source_adc, source_receiver
	} dac_source_type;
	typedef struct packed {
		logic signed [`SAMPLE_W-1:0] left;
		logic signed [`SAMPLE_W-1:0] right;
	} stereo_type;
	typedef struct packed {
		logic [`SAMPLE_W-1:0] attack_threshold;
		logic [`SAMPLE_W-1:0] recovery_threshold;
		logic [`TIME_W-1:0] attack_time;
		logic [`TIME_W-1:0] recovery_time;
		recovery_mode_type recovery_mode;
		logic both_channels;
		logic [`COUNT_W-1:0] excursion_max;
	} alc_settings_type;
	typedef struct packed {
		logic [7:0] adc_div;
		logic adc_strobe;
		logic [1:0] mod_div;
		logic mod_tick;
		logic quarter;
		logic enable_seen;
		alc_settings_type settings;
		logic [`GAIN_W-1:0] gain_init_l;
		logic [`GAIN_W-1:0] gain_init_r;
		logic [`GAIN_W-1:0] offset;
		logic [`GAIN_W-1:0] gain_l;
		logic [`GAIN_W-1:0] gain_r;
		alc_state_type alc_state;
		logic [`TIME_W-1:0] timer;
		logic excursion_seen;
		logic [`COUNT_W-1:0] excursion_count;
		logic attack_active;
		logic dac_phase;
		logic [7:0] dac_cnt;
		logic dac_tick;
		logic dac_strobe;
		logic half_mclk;
		logic interp_4x;
		logic [1:0] mute;
		stereo_type dac_out;
		logic [`SAMPLE_W-1:0] peak_l;
		logic [`SAMPLE_W-1:0] peak_r;
	} control_state_type;
endpackage

// >>> rtl/codec_level_and_clock_control.sv
// Level control, converter clock division and DAC datapath control
// How it works
// - After attack, limited recovery restores gain step by step toward programmed value
// - Count one excursion per recovery interval with output above recovery threshold
// - Excursion count at programmed maximum stops all further recovery, gain held
// - Output above attack threshold restarts attack and clears the excursion count
// - ADC sample strobe is master clock divided by 256 in every modulator mode
// - Modulator runs at master clock over 2, or over 4 with alternative filters
// - DAC input selectable: playback, auxiliary, rate converter, ADC or receiver
// - Each DAC channel has 256-step volume, about 0.375 dB per step
// - Both DAC channels muted from reset until software unmutes them
// - Per-channel peak register tracks data peak, read clears it
// - DAC default expects 256 fs master clock with 8x interpolation
// - Attack lowers both gains one 0.5 dB step per attack time while over
// - Gain and level-control writes ignored while level control enabled
// - Gains never exceed programmed values, left-right difference kept
// - Enable toggle or third control register write resets level control
`timescale 1ns/10ps
`include "codec_ctl_consts.svh"
module codec_level_and_clock_control #(
	parameter int ADC_RATE_DIV = `ADC_RATE_DIV
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic modulator_clock_quarter_select,
	input wire logic adc_sample_valid,
	input wire codec_pkg::stereo_type adc_sample,
	input wire logic level_control_enable,
	input wire logic pga_gain_write,
	input wire logic [`GAIN_W-1:0] pga_gain_left,
	input wire logic [`GAIN_W-1:0] pga_gain_right,
	input wire logic alc_settings_write,
	input wire codec_pkg::alc_settings_type alc_settings,
	input wire logic alc_reset_write,
	input wire codec_pkg::dac_source_type dac_source_select,
	input wire codec_pkg::stereo_type playback_data,
	input wire codec_pkg::stereo_type auxiliary_data,
	input wire codec_pkg::stereo_type rate_converter_data,
	input wire codec_pkg::stereo_type receiver_data,
	input wire logic [`VOL_W-1:0] dac_volume_left,
	input wire logic [`VOL_W-1:0] dac_volume_right,
	input wire logic dac_mute_write,
	input wire logic [1:0] dac_mute_value,
	input wire logic dac_mclk_half,
	input wire logic dac_interp_quad,
	input wire logic peak_read_left,
	input wire logic peak_read_right,
	output logic adc_sample_strobe,
	output logic modulator_tick,
	output logic decimator_alt_filters,
	output logic [`GAIN_W-1:0] pga_gain_out_left,
	output logic [`GAIN_W-1:0] pga_gain_out_right,
	output logic [`COUNT_W-1:0] recovery_excursion_count,
	output logic alc_attack_active,
	output logic dac_engine_tick,
	output logic dac_sample_strobe,
	output logic dac_interp_4x,
	output logic [1:0] dac_mute_state,
	output codec_pkg::stereo_type dac_data,
	output logic [`SAMPLE_W-1:0] peak_level_left,
	output logic [`SAMPLE_W-1:0] peak_level_right
);
	import codec_pkg::*;

	localparam int ADC_GAP = ADC_RATE_DIV - 1;
	localparam logic [7:0] ADC_LAST = 8'(ADC_RATE_DIV - 1);
	// Entry 0 is unity, so step 0 of each group applies only that group's halvings
	localparam logic [8:0] VOL_MANT [16] = '{9'h100, 9'h0f4, 9'h0ea, 9'h0e0, 9'h0d7, 9'h0ce,
		9'h0c5, 9'h0bd, 9'h0b5, 9'h0ad, 9'h0a6, 9'h09f, 9'h098, 9'h092, 9'h08c, 9'h086};

	if (ADC_RATE_DIV < 4 || ADC_RATE_DIV > 256 ||
		(ADC_RATE_DIV & (ADC_RATE_DIV - 1)) != 0) begin : g_bad_rate
		$error("ADC_RATE_DIV must be a power of two from 4 to 256");
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [`SAMPLE_W-1:0] magnitude(input logic signed [`SAMPLE_W-1:0] x);
		magnitude = x[`SAMPLE_W-1] ? `SAMPLE_W'(~x + 1'b1) : `SAMPLE_W'(x);
	endfunction

	// Log-like attenuation: halving per 16 steps, table within each group
	function automatic logic signed [`SAMPLE_W-1:0] attenuate(
		input logic signed [`SAMPLE_W-1:0] x, input logic [`VOL_W-1:0] vol);
		logic signed [`SAMPLE_W+8:0] prod;
		prod = '0;
		prod = x * $signed({1'b0, VOL_MANT[vol[`VOL_FRAC_BITS-1:0]]});
		prod = prod >>> `VOL_MANT_SHIFT;
		prod = prod >>> vol[`VOL_W-1:`VOL_FRAC_BITS];
		attenuate = prod[`SAMPLE_W-1:0];
	endfunction

	control_state_type s;
	control_state_type next_s;
	logic over_attack;
	logic over_recovery;
	logic [`GAIN_W-1:0] gain_cap;
	stereo_type dac_source;

	always_comb begin
		logic att_l;
		logic att_r;
		logic rec_l;
		logic rec_r;
		att_l = magnitude(adc_sample.left) > s.settings.attack_threshold;
		att_r = magnitude(adc_sample.right) > s.settings.attack_threshold;
		rec_l = magnitude(adc_sample.left) > s.settings.recovery_threshold;
		rec_r = magnitude(adc_sample.right) > s.settings.recovery_threshold;
		over_attack = s.settings.both_channels ? (att_l && att_r) : (att_l || att_r);
		over_recovery = s.settings.both_channels ? (rec_l && rec_r) : (rec_l || rec_r);
		gain_cap = (s.gain_init_l < s.gain_init_r) ? s.gain_init_l : s.gain_init_r;
	end

	always_comb begin
		case (dac_source_select)
			source_auxiliary: dac_source = auxiliary_data;
			source_rate_converter: dac_source = rate_converter_data;
			source_adc: dac_source = adc_sample;
			source_receiver: dac_source = receiver_data;
			default: dac_source = playback_data;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic step_down;
		logic [1:0] mod_limit;
		logic [7:0] dac_limit;
		logic tick;
		step_down = 1'b0;
		mod_limit = `MOD_LIMIT_HALF;
		dac_limit = `DAC_LIMIT_8X;
		tick = 1'b0;
		next_s = s;
		// Converter clocks
		next_s.adc_strobe = (s.adc_div == ADC_LAST);
		next_s.adc_div = next_s.adc_strobe ? 8'h00 : s.adc_div + 8'h01;
		next_s.quarter = modulator_clock_quarter_select;
		mod_limit = s.quarter ? `MOD_LIMIT_QUARTER : `MOD_LIMIT_HALF;
		next_s.mod_tick = (s.mod_div >= mod_limit);
		next_s.mod_div = next_s.mod_tick ? 2'h0 : s.mod_div + 2'h1;
		// Level control
		next_s.enable_seen = level_control_enable;
		if (!level_control_enable) begin
			if (pga_gain_write) begin
				next_s.gain_init_l = pga_gain_left;
				next_s.gain_init_r = pga_gain_right;
			end
			if (alc_settings_write) begin
				next_s.settings = alc_settings;
			end
		end
		if (level_control_enable != s.enable_seen || alc_reset_write) begin
			next_s.offset = '0;
			next_s.excursion_count = '0;
			next_s.alc_state = alc_idle;
			next_s.timer = '0;
			next_s.excursion_seen = 1'b0;
		end else if (level_control_enable && adc_sample_valid) begin
			if (s.timer != '0) begin
				next_s.timer = s.timer - `TIME_W'(1);
			end
			case (s.alc_state)
				alc_attack: begin
					if (s.timer == '0) begin
						if (over_attack) begin
							step_down = 1'b1;
						end else begin
							next_s.alc_state = alc_recover;
							next_s.timer = s.settings.recovery_time;
							next_s.excursion_seen = 1'b0;
						end
					end
				end
				default: begin
					if (over_attack) begin
						step_down = 1'b1;
					end else if (s.alc_state == alc_recover) begin
						next_s.excursion_seen = s.excursion_seen || over_recovery;
						if (s.timer == '0) begin
							next_s.timer = s.settings.recovery_time;
							next_s.excursion_seen = 1'b0;
							if (s.excursion_seen || over_recovery) begin
								if (s.settings.recovery_mode == recovery_limited &&
									s.excursion_count != s.settings.excursion_max) begin
									next_s.excursion_count = s.excursion_count + `COUNT_W'(1);
								end
							end else if (s.settings.recovery_mode != recovery_none && s.offset != '0 &&
								!(s.settings.recovery_mode == recovery_limited &&
								s.excursion_count == s.settings.excursion_max)) begin
								next_s.offset = s.offset - `GAIN_W'(1);
							end
						end
					end
				end
			endcase
			if (step_down) begin
				next_s.alc_state = alc_attack;
				next_s.timer = s.settings.attack_time;
				next_s.excursion_count = '0;
				if (s.offset < gain_cap) begin
					next_s.offset = s.offset + `GAIN_W'(1);
				end
			end
		end
		next_s.gain_l = s.gain_init_l - s.offset;
		next_s.gain_r = s.gain_init_r - s.offset;
		next_s.attack_active = (s.alc_state == alc_attack);
		// DAC clocking
		next_s.half_mclk = dac_mclk_half;
		next_s.interp_4x = dac_interp_quad;
		next_s.dac_phase = s.half_mclk ? !s.dac_phase : 1'b0;
		tick = !s.half_mclk || s.dac_phase;
		next_s.dac_tick = tick;
		dac_limit = s.interp_4x ? `DAC_LIMIT_4X : `DAC_LIMIT_8X;
		next_s.dac_strobe = tick && (s.dac_cnt >= dac_limit);
		if (tick) begin
			next_s.dac_cnt = next_s.dac_strobe ? 8'h00 : s.dac_cnt + 8'h01;
		end
		// DAC datapath
		if (dac_mute_write) begin
			next_s.mute = dac_mute_value;
		end
		if (s.dac_strobe) begin
			next_s.dac_out.left = s.mute[0] ? '0 : attenuate(dac_source.left, dac_volume_left);
			next_s.dac_out.right = s.mute[1] ? '0 : attenuate(dac_source.right, dac_volume_right);
		end
		// Peak capture: a fresh sample wins over a read clear
		if (peak_read_left) begin
			next_s.peak_l = '0;
		end
		if (peak_read_right) begin
			next_s.peak_r = '0;
		end
		if (s.dac_strobe && magnitude(dac_source.left) > next_s.peak_l) begin
			next_s.peak_l = magnitude(dac_source.left);
		end
		if (s.dac_strobe && magnitude(dac_source.right) > next_s.peak_r) begin
			next_s.peak_r = magnitude(dac_source.right);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.alc_state <= alc_idle;
			s.mute <= `MUTE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign adc_sample_strobe = s.adc_strobe;
	assign modulator_tick = s.mod_tick;
	assign decimator_alt_filters = s.quarter;
	assign pga_gain_out_left = s.gain_l;
	assign pga_gain_out_right = s.gain_r;
	assign recovery_excursion_count = s.excursion_count;
	assign alc_attack_active = s.attack_active;
	assign dac_engine_tick = s.dac_tick;
	assign dac_sample_strobe = s.dac_strobe;
	assign dac_interp_4x = s.interp_4x;
	assign dac_mute_state = s.mute;
	assign dac_data = s.dac_out;
	assign peak_level_left = s.peak_l;
	assign peak_level_right = s.peak_r;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence alc_live;
		level_control_enable && s.enable_seen && !alc_reset_write && adc_sample_valid;
	endsequence
	sequence attack_entry;
		alc_live ##0 (over_attack && s.alc_state != alc_attack && s.offset < gain_cap);
	endsequence

	property p_excursion_cap;
		s.settings.recovery_mode == recovery_limited |-> s.excursion_count <= s.settings.excursion_max;
	endproperty
	a_excursion_cap: assert property (p_excursion_cap) else $error("excursion count over max");

	property p_attack_clears;
		attack_entry |=> s.excursion_count == '0 && s.offset == $past(s.offset) + `GAIN_W'(1)
			&& s.alc_state == alc_attack;
	endproperty
	a_attack_clears: assert property (p_attack_clears) else $error("attack entry wrong");

	property p_adc_rate;
		s.adc_strobe |-> ##1 !s.adc_strobe ##[ADC_GAP:ADC_GAP] s.adc_strobe;
	endproperty
	a_adc_rate: assert property (p_adc_rate) else $error("ADC strobe period wrong");

	property p_mod_half;
		s.mod_tick ##1 !s.quarter |-> ##1 s.mod_tick;
	endproperty
	a_mod_half: assert property (p_mod_half) else $error("modulator divide by 2 wrong");

	property p_mute_output;
		s.dac_strobe && s.mute[0] |=> s.dac_out.left == '0;
	endproperty
	a_mute_output: assert property (p_mute_output) else $error("muted channel not silent");

	property p_peak_clear;
		peak_read_left && !s.dac_strobe |=> s.peak_l == '0;
	endproperty
	a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared on read");

	property p_gain_track;
		level_control_enable && $stable(s.gain_init_l) && $stable(s.gain_init_r) && $stable(s.offset)
			|-> s.gain_l <= s.gain_init_l && s.gain_r <= s.gain_init_r &&
			(s.gain_init_l - s.gain_l) == (s.gain_init_r - s.gain_r);
	endproperty
	a_gain_track: assert property (p_gain_track) else $error("gain cap or balance broken");

	property p_settings_locked;
		level_control_enable && s.enable_seen |=> $stable(s.settings) && $stable(s.gain_init_l);
	endproperty
	a_settings_locked: assert property (p_settings_locked) else $error("write taken while enabled");

	property p_reset_clears;
		alc_reset_write || $fell(level_control_enable) |=> s.offset == '0 && s.excursion_count == '0;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("level control not reset");
endmodule

// >>> sim/codec_far_side.sv
// Far-side model: ADC converter core handing decimated words to the block
`timescale 1ns/10ps
`include "codec_ctl_consts.svh"
module codec_far_side (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic adc_sample_strobe,
	input wire logic [`SAMPLE_W-1:0] level,
	output logic adc_sample_valid,
	output codec_pkg::stereo_type adc_sample
);
	import codec_pkg::*;
	logic flip;
	////////////////////////////////////////////////////////////////
	// One word per output-rate strobe, channel signs alternate
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			adc_sample_valid <= 1'b0;
			adc_sample <= '0;
			flip <= 1'b0;
		end else begin
			adc_sample_valid <= adc_sample_strobe;
			if (adc_sample_strobe) begin
				flip <= ~flip;
				adc_sample.left <= flip ? -level : level;
				adc_sample.right <= flip ? level : -level;
			end else begin
				// Word no longer held: scramble it
				adc_sample <= ~adc_sample;
			end
		end
	end
endmodule

// >>> sim/codec_level_and_clock_control_tb.sv
// Self-checking bench for the codec level and clock control block
`timescale 1ns/10ps
`include "codec_ctl_consts.svh"
module codec_level_and_clock_control_tb;
	import codec_pkg::*;
	localparam int DIV = 16;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic quarter = 1'b0;
	logic enable = 1'b0;
	logic [5:0] pulses = '0;
	logic [`GAIN_W-1:0] gain_l = '0;
	logic [`GAIN_W-1:0] gain_r = '0;
	alc_settings_type settings = '0;
	dac_source_type source = source_playback;
	stereo_type src [5] = '{default: '0};
	logic [`VOL_W-1:0] vol_l = '0;
	logic [`VOL_W-1:0] vol_r = '0;
	logic [1:0] mute_value = '0;
	logic half = 1'b0;
	logic quad = 1'b0;
	logic [`SAMPLE_W-1:0] level = '0;
	logic adc_sample_strobe, modulator_tick, alt_filters, attack, engine_tick, dac_sample_strobe;
	logic interp_4x, adc_sample_valid;
	logic [`GAIN_W-1:0] gout_l, gout_r;
	logic [`COUNT_W-1:0] count;
	logic [1:0] mute_state;
	logic [`SAMPLE_W-1:0] peak_l, peak_r;
	stereo_type dac_data, adc_sample, exp;
	wire [3:0] ticks = {engine_tick, dac_sample_strobe, modulator_tick, adc_sample_strobe};
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int pl = 0;
	int pr = 0;
	int p;
	codec_level_and_clock_control #(.ADC_RATE_DIV(DIV)) uut (.clock(clock), .sys_rst(sys_rst),
		.modulator_clock_quarter_select(quarter), .adc_sample_valid(adc_sample_valid),
		.adc_sample(adc_sample), .level_control_enable(enable), .pga_gain_write(pulses[0]),
		.pga_gain_left(gain_l), .pga_gain_right(gain_r), .alc_settings_write(pulses[1]),
		.alc_settings(settings), .alc_reset_write(pulses[2]), .dac_source_select(source),
		.playback_data(src[0]), .auxiliary_data(src[1]), .rate_converter_data(src[2]),
		.receiver_data(src[4]), .dac_volume_left(vol_l), .dac_volume_right(vol_r),
		.dac_mute_write(pulses[3]), .dac_mute_value(mute_value), .dac_mclk_half(half),
		.dac_interp_quad(quad), .peak_read_left(pulses[4]), .peak_read_right(pulses[5]),
		.adc_sample_strobe(adc_sample_strobe), .modulator_tick(modulator_tick),
		.decimator_alt_filters(alt_filters), .pga_gain_out_left(gout_l),
		.pga_gain_out_right(gout_r), .recovery_excursion_count(count),
		.alc_attack_active(attack), .dac_engine_tick(engine_tick),
		.dac_sample_strobe(dac_sample_strobe), .dac_interp_4x(interp_4x),
		.dac_mute_state(mute_state), .dac_data(dac_data), .peak_level_left(peak_l),
		.peak_level_right(peak_r));
	codec_far_side partner (.clock(clock), .sys_rst(sys_rst), .adc_sample_strobe(adc_sample_strobe),
		.level(level), .adc_sample_valid(adc_sample_valid), .adc_sample(adc_sample));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] want);
		samples_checked++;
		if (seen !== want) begin
			errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic pulse(input int i);
		pulses[i] <= 1'b1;
		@(posedge clock);
		pulses <= '0;
		@(posedge clock);
	endtask
	task automatic period(input int k, output int n);
		n = 0;
		do @(posedge clock); while (ticks[k] !== 1'b1);
		do begin
			@(posedge clock);
			n++;
		end while (ticks[k] !== 1'b1 && n < 600);
	endtask
	// Hold a level over n converter words, then let gains settle
	task automatic feed(input logic [23:0] lv, input int n);
		level <= lv;
		do @(posedge clock); while (adc_sample_strobe !== 1'b1);
		repeat (n) do @(posedge clock); while (adc_sample_valid !== 1'b1);
		repeat (3) @(posedge clock);
	endtask
	task automatic automatic_level_control(input int gl, input int gr, input int c);
		check("gain_left", gout_l, gl);
		check("gain_right", gout_r, gr);
		check("excursions", count, c);
	endtask
	function automatic int mag(input logic signed [23:0] x);
		return x < 0 ? -x : x;
	endfunction
	// Next DAC word taken from the selected source, folded into the peak model
	task automatic dac_word(input int s);
		do @(posedge clock); while (dac_sample_strobe !== 1'b1);
		exp = (s == 3) ? adc_sample : (s == 5) ? src[0] : src[s];
		pl = mag(exp.left) > pl ? mag(exp.left) : pl;
		pr = mag(exp.right) > pr ? mag(exp.right) : pr;
		@(posedge clock);
	endtask
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hb5fa));
		@(posedge clock);
		#1;
		check("mute_in_reset", mute_state, 2'h3);
		repeat (7) @(posedge clock);
		sys_rst <= 1'b0;
		for (int q = 0; q < 2; q++) begin
			quarter <= q[0];
			period(1, p);
			period(1, p);
			check("modulator_period", p, q ? 4 : 2);
			check("alt_filters", alt_filters, q[0]);
			period(0, p);
			check("adc_period", p, DIV);
		end
		for (int c = 0; c < 4; c++) begin
			half <= c[0];
			quad <= c[1];
			period(2, p);
			period(2, p);
			check("dac_period", p, (c[0] ? 2 : 1) * (c[1] ? 128 : 256));
			check("interp_4x", interp_4x, c[1]);
			period(3, p);
			check("engine_period", p, c[0] ? 2 : 1);
		end
		half <= 1'b0;
		quad <= 1'b0;
		$display("test clocks done");
		src[0] <= '{24'h123456, 24'h654321};
		dac_word(0);
		check("muted_data", dac_data, 48'h0);
		pulse(4);
		pulse(5);
		check("peak_cleared_left", peak_l, 24'h0);
		check("peak_cleared_right", peak_r, 24'h0);
		pl = 0;
		pr = 0;
		mute_value <= 2'h0;
		pulse(3);
		check("unmuted", mute_state, 2'h0);
		for (int s = 0; s < 6; s++) begin
			for (int i = 0; i < 5; i++) begin
				src[i].left <= $urandom_range(24'h7fffff);
				src[i].right <= -$urandom_range(24'h7fffff);
			end
			source <= dac_source_type'(s[2:0]);
			dac_word(s);
			check("dac_data", dac_data, exp);
		end
		check("peak_left", peak_l, pl);
		check("peak_right", peak_r, pr);
		pulse(4);
		check("peak_read_left", peak_l, 24'h0);
		check("peak_kept_right", peak_r, pr);
		src[0] <= '{24'h100000, 24'h100000};
		vol_l <= 8'h10;
		vol_r <= 8'h20;
		source <= source_playback;
		dac_word(0);
		check("volume", dac_data, {24'h080000, 24'h040000});
		$display("test dac done");
		settings <= '{24'h400000, 24'h200000, 8'h0, 8'h0, recovery_limited, 1'b0, 4'h2};
		gain_l <= 6'h14;
		gain_r <= 6'h0a;
		pulse(0);
		pulse(1);
		enable <= 1'b1;
		feed(24'h500000, 3);
		automatic_level_control(17, 7, 0);
		check("attack_active", attack, 1'b1);
		feed(24'h300000, 6);
		automatic_level_control(17, 7, 2);
		feed(24'h001000, 6);
		automatic_level_control(17, 7, 2);
		feed(24'h500000, 1);
		automatic_level_control(16, 6, 0);
		feed(24'h001000, 10);
		automatic_level_control(20, 10, 0);
		gain_l <= 6'h05;
		gain_r <= 6'h05;
		pulse(0);
		feed(24'h500000, 2);
		automatic_level_control(18, 8, 0);
		pulse(2);
		repeat (2) @(posedge clock);
		automatic_level_control(20, 10, 0);
		feed(24'h500000, 1);
		feed(24'h300000, 4);
		automatic_level_control(19, 9, 2);
		enable <= 1'b0;
		repeat (3) @(posedge clock);
		automatic_level_control(20, 10, 0);
		pulse(0);
		repeat (2) @(posedge clock);
		automatic_level_control(5, 5, 0);
		settings.recovery_mode <= recovery_normal;
		pulse(1);
		enable <= 1'b1;
		feed(24'h500000, 2);
		automatic_level_control(3, 3, 0);
		feed(24'h300000, 4);
		automatic_level_control(3, 3, 0);
		feed(24'h001000, 4);
		automatic_level_control(5, 5, 0);
		$display("test level control done");
		print_verdict();
	end
endmodule
